//--- rtl/tdm_switch_params.svh
// constants of the connection memory and throughput delay block
`ifndef TDM_SWITCH_PARAMS_SVH
`define TDM_SWITCH_PARAMS_SVH
// host port map: addr[14:13] picks the area
`define ADDR_CR 15'h0000
`define ADDR_IMS 15'h0001
`define ADDR_STATUS 15'h0002
`define AREA_CM_LOW 2'h2
`define AREA_CM_HIGH 2'h3
// control register fields
`define CR_VAR_EN_BIT 4
`define CR_BPE_BIT 3
// mode selection register fields
`define IMS_START_BIT 0
`define IMS_PAT_LSB 1
`define IMS_PAT_MSB 3
// low connection word fields
`define CW_LAW_EN_BIT 15
`define CW_VAR_BIT 14
`define CW_SSA_MSB 13
`define CW_SSA_LSB 9
`define CW_SCA_MSB 8
`define CW_SCA_LSB 1
`define CW_MSG_MSB 10
`define CW_MSG_LSB 3
`define CW_SPECIAL_BIT 0
// reset values and fills
`define CR_RESET 1'b0
`define IMS_PAT_RESET 3'h0
`define INVALID_BYTE 8'hFF
`define LAST_CM_INDEX 13'h1FFF
`define LAST_STREAM 5'h1F
`define LAST_CHANNEL 8'hFF
`define LAST_BANK 2'h2
// timing
`define VAR_MIN_SLOTS 9'sh007
`define CLK_PERIOD_NS 5
`define BLOCK_MIN_NS 250000
`define BLOCK_CYCLES ((`BLOCK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

//--- rtl/tdm_switch_pkg.sv
// types shared by the switch connection memory modules
package tdm_switch_pkg;
   typedef enum logic [1:0] {
      bp_idle = 2'h0,
      bp_clear = 2'h1,
      bp_wait = 2'h3
   } bp_state_type;

   typedef struct packed {
      logic [4:0] stream;
      logic [7:0] channel;
      logic [7:0] data;
      logic law_en;
      logic [4:0] law_bits;
   } out_word_type;
endpackage

//--- rtl/buffer_link_if.sv
// valid/ready link carrying one output word into the buffer
`timescale 1ns/1ps
`default_nettype none
interface buffer_link_if;
   import tdm_switch_pkg::*;
   logic valid;
   logic ready;
   out_word_type data;
   modport source (output valid, output data, input ready);
   modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- rtl/out_buffer.sv
// two-entry output buffer between the switch walker and the receiver
`timescale 1ns/1ps
`default_nettype none
module out_buffer (
   input wire logic ref_clk,
   input wire logic reset_n,
   buffer_link_if.sink fill,
   output logic drain_valid,
   input wire logic drain_ready,
   output var tdm_switch_pkg::out_word_type drain_data
);
   import tdm_switch_pkg::*;

   out_word_type entry1, next_entry0, next_entry1;
   logic [1:0] count, next_count;
   logic push, pop;

   // ready depends on registered count only, so no path from drain_ready
   assign fill.ready = (count != 2'h2);
   assign push = fill.valid && fill.ready;
   assign pop = drain_valid && drain_ready;

   always_comb begin
      next_entry0 = drain_data;
      next_entry1 = entry1;
      next_count = count;
      if (pop) begin
         next_entry0 = entry1;
         next_count = next_count - 2'h1;
      end
      if (push) begin
         if (next_count == 2'h0) begin
            next_entry0 = fill.data;
         end else begin
            next_entry1 = fill.data;
         end
         next_count = next_count + 2'h1;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         drain_data <= '0;
         entry1 <= '0;
         count <= 2'h0;
         drain_valid <= 1'b0;
      end else begin
         drain_data <= next_entry0;
         entry1 <= next_entry1;
         count <= next_count;
         drain_valid <= (next_count != 2'h0);
      end
   end
endmodule
`default_nettype wire

//--- rtl/tdm_switch_connection_memory.sv
// connection memory, block programming and throughput delay of the switch
//
// Functional notes
// - variable delay sends a channel at the earliest slot, 7 slots to frame+7.
// - with special mode clear, low word bit 14 picks variable (1) or constant (0).
// - variable latency follows n-m, with output/input stream tie-break at n-m=7.
// - constant delay is two frames plus n-m slots.
// - constant selection still honoured while chip-wide variable enable is set.
// - 16-bit low and 5-bit high words per channel, one access, zero padding.
// - law enable clear disables conversion and ignores the high word.
// - normal switching takes source channel bits 8..1, source stream 13..9.
// - special mode set sends message byte bits 10..3 on the output channel.
// - block program writes pattern to low bits 2..0, zeroes all else.
// - high word bits 15..5 are always zero.
// - block program lasts at least two frames, then start self-clears.
// - clearing start or enable aborts; after enable abort host clears start.
`timescale 1ns/1ps
`default_nettype none
`include "tdm_switch_params.svh"
module tdm_switch_connection_memory #(
   parameter int BLOCK_CYCLES = `BLOCK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic host_cs_n,
   input wire logic host_ds_n,
   input wire logic host_rw,
   input wire logic [14:0] host_addr,
   input wire logic [15:0] host_data_in,
   output logic [15:0] host_data_out,
   output logic host_data_oe,
   output logic host_ack_n,
   input wire logic frame_pulse,
   input wire logic in_valid,
   input wire logic [4:0] in_stream,
   input wire logic [7:0] in_channel,
   input wire logic [7:0] in_byte,
   output logic out_valid,
   input wire logic out_ready,
   output logic [4:0] out_stream,
   output logic [7:0] out_channel,
   output logic [7:0] out_byte,
   output logic out_law_enable,
   output logic [4:0] out_law_bits
);
   import tdm_switch_pkg::*;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   // ----------------------------------------------------------------
   // memories
   // ----------------------------------------------------------------
   logic [15:0] cm_low [0:8191];
   logic [4:0] cm_high [0:8191];
   // three frame banks so constant delay can reach two frames back
   logic [7:0] data_mem [0:32767];

   function automatic logic [1:0] bank_back(input logic [1:0] b, input logic [1:0] k);
      logic [2:0] t;
      t = {1'b0, b} + 3'h3 - {1'b0, k};
      return (t >= 3'h3) ? 2'(t - 3'h3) : t[1:0];
   endfunction

   function automatic logic is_area(input logic [14:0] a, input logic [1:0] area);
      return a[14:13] == area;
   endfunction

   // ----------------------------------------------------------------
   // host port synchroniser
   // ----------------------------------------------------------------
   logic [33:0] pin_meta, pin_sync;
   logic strobe_prev;
   logic strobe_s, rw_s, acc_pulse, acc_write;
   logic [14:0] addr_s;
   logic [15:0] wdata_s;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta <= {2'h3, 32'h0};
         pin_sync <= {2'h3, 32'h0};
         strobe_prev <= 1'b0;
      end else begin
         pin_meta <= {host_cs_n, host_ds_n, host_rw, host_addr, host_data_in};
         pin_sync <= pin_meta;
         strobe_prev <= strobe_s;
      end
   end

   assign strobe_s = !pin_sync[33] && !pin_sync[32];
   assign rw_s = pin_sync[31];
   assign addr_s = pin_sync[30:16];
   assign wdata_s = pin_sync[15:0];
   assign acc_pulse = strobe_s && !strobe_prev;
   assign acc_write = acc_pulse && !rw_s;

   // ----------------------------------------------------------------
   // control and mode selection registers
   // ----------------------------------------------------------------
   logic var_en, bpe, start, start_q;
   logic next_var_en, next_bpe, next_start;
   logic [2:0] pattern, next_pattern;
   logic bp_done, bp_write, wr_cr, wr_ims;
   bp_state_type state, next_state;
   logic [12:0] clr_idx, next_clr_idx;
   logic [31:0] run_cnt, next_run_cnt;
   logic [1:0] bank;

   assign wr_cr = acc_write && (addr_s == `ADDR_CR);
   assign wr_ims = acc_write && (addr_s == `ADDR_IMS);

   always_comb begin
      next_var_en = var_en;
      next_bpe = bpe;
      next_pattern = pattern;
      next_start = start;
      if (bp_done) begin
         next_start = 1'b0;
      end
      if (wr_cr) begin
         next_var_en = wdata_s[`CR_VAR_EN_BIT];
         next_bpe = wdata_s[`CR_BPE_BIT];
      end
      // a host write in the completion cycle wins over the self-clear
      if (wr_ims) begin
         next_pattern = wdata_s[`IMS_PAT_MSB:`IMS_PAT_LSB];
         next_start = wdata_s[`IMS_START_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         var_en <= `CR_RESET;
         bpe <= `CR_RESET;
         pattern <= `IMS_PAT_RESET;
         start <= `CR_RESET;
         start_q <= `CR_RESET;
      end else begin
         var_en <= next_var_en;
         bpe <= next_bpe;
         pattern <= next_pattern;
         start <= next_start;
         start_q <= start;
      end
   end

   // ----------------------------------------------------------------
   // block programming sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_clr_idx = clr_idx;
      next_run_cnt = run_cnt;
      bp_done = 1'b0;
      bp_write = 1'b0;
      case (state)
         bp_idle: begin
            // a rising start is needed, so a start left high after abort cannot rerun
            if (bpe && start && !start_q) begin
               next_state = bp_clear;
               next_clr_idx = 13'h0;
               next_run_cnt = 32'h0;
            end
         end
         bp_clear: begin
            bp_write = 1'b1;
            next_run_cnt = run_cnt + 32'h1;
            next_clr_idx = clr_idx + 13'h1;
            if (clr_idx == `LAST_CM_INDEX) begin
               next_state = bp_wait;
            end
         end
         bp_wait: begin
            next_run_cnt = run_cnt + 32'h1;
            if (run_cnt >= 32'(BLOCK_CYCLES - 1)) begin
               bp_done = 1'b1;
               next_state = bp_idle;
            end
         end
         default: begin
            next_state = bp_idle;
         end
      endcase
      if (state != bp_idle && (!bpe || !start)) begin
         bp_write = 1'b0;
         bp_done = 1'b0;
         next_state = bp_idle;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= bp_idle;
         clr_idx <= 13'h0;
         run_cnt <= 32'h0;
      end else begin
         state <= next_state;
         clr_idx <= next_clr_idx;
         run_cnt <= next_run_cnt;
      end
   end

   // ----------------------------------------------------------------
   // host answer
   // ----------------------------------------------------------------
   logic [15:0] rd_value, next_data_out;
   logic next_oe, next_ack_n;

   always_comb begin
      rd_value = 16'h0;
      if (is_area(addr_s, `AREA_CM_LOW)) begin
         rd_value = cm_low[addr_s[12:0]];
      end else if (is_area(addr_s, `AREA_CM_HIGH)) begin
         rd_value = {11'h0, cm_high[addr_s[12:0]]};
      end else if (addr_s == `ADDR_CR) begin
         rd_value = {11'h0, var_en, bpe, 3'h0};
      end else if (addr_s == `ADDR_IMS) begin
         rd_value = {12'h0, pattern, start};
      end else if (addr_s == `ADDR_STATUS) begin
         rd_value = {12'h0, bank, state != bp_idle, state == bp_wait};
      end
      next_data_out = host_data_out;
      next_oe = host_data_oe;
      next_ack_n = host_ack_n;
      if (acc_pulse) begin
         next_data_out = rw_s ? rd_value : 16'h0;
         next_oe = rw_s;
         next_ack_n = 1'b0;
      end else if (!strobe_s) begin
         next_oe = 1'b0;
         next_ack_n = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         host_data_out <= 16'h0;
         host_data_oe <= 1'b0;
         host_ack_n <= 1'b1;
      end else begin
         host_data_out <= next_data_out;
         host_data_oe <= next_oe;
         host_ack_n <= next_ack_n;
      end
   end

   // ----------------------------------------------------------------
   // memory writes: sequencer first, host connection writes during a block program are dropped
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (bp_write) begin
         cm_low[clr_idx] <= {13'h0, pattern};
         cm_high[clr_idx] <= 5'h0;
      end else if (acc_write && state == bp_idle) begin
         if (is_area(addr_s, `AREA_CM_LOW)) begin
            cm_low[addr_s[12:0]] <= wdata_s;
         end else if (is_area(addr_s, `AREA_CM_HIGH)) begin
            cm_high[addr_s[12:0]] <= wdata_s[4:0];
         end
      end
      if (in_valid) begin
         data_mem[{bank, in_stream, in_channel}] <= in_byte;
      end
   end

   // ----------------------------------------------------------------
   // frame banks and output walker
   // ----------------------------------------------------------------
   logic [1:0] next_bank, rd_bank;
   logic [7:0] out_ch, next_out_ch, last_in_ch, next_last_in_ch;
   logic [4:0] out_st, next_out_st;
   logic walk_on, next_walk_on, seen_in, next_seen_in;
   logic [15:0] word;
   logic signed [8:0] diff;
   logic same_frame, push;
   out_word_type push_word;
   buffer_link_if link ();

   assign word = cm_low[{out_st, out_ch}];
   assign diff = $signed({1'b0, out_ch}) - $signed({1'b0, word[`CW_SCA_MSB:`CW_SCA_LSB]});
   assign same_frame = (diff > `VAR_MIN_SLOTS) ||
      ((diff == `VAR_MIN_SLOTS) && (out_st >= word[`CW_SSA_MSB:`CW_SSA_LSB]));

   always_comb begin
      rd_bank = bank_back(bank, 2'h2);
      if (word[`CW_VAR_BIT]) begin
         rd_bank = same_frame ? bank : bank_back(bank, 2'h1);
      end
      push_word.stream = out_st;
      push_word.channel = out_ch;
      push_word.law_en = word[`CW_LAW_EN_BIT];
      push_word.law_bits = word[`CW_LAW_EN_BIT] ? cm_high[{out_st, out_ch}] : 5'h0;
      push_word.data = data_mem[{rd_bank, word[`CW_SSA_MSB:`CW_SSA_LSB],
         word[`CW_SCA_MSB:`CW_SCA_LSB]}];
      if (word[`CW_SPECIAL_BIT]) begin
         push_word.data = word[`CW_MSG_MSB:`CW_MSG_LSB];
      end else if (word[`CW_VAR_BIT] && !var_en) begin
         push_word.data = `INVALID_BYTE;
      end
   end

   // the walker stays behind the input so same-frame sources are written
   assign link.valid = walk_on && seen_in && (out_ch <= last_in_ch);
   assign link.data = push_word;
   assign push = link.valid && link.ready;

   always_comb begin
      next_bank = bank;
      next_out_ch = out_ch;
      next_out_st = out_st;
      next_walk_on = walk_on;
      next_seen_in = seen_in;
      next_last_in_ch = last_in_ch;
      if (in_valid) begin
         next_seen_in = 1'b1;
         next_last_in_ch = in_channel;
      end
      if (push) begin
         next_out_st = out_st + 5'h1;
         if (out_st == `LAST_STREAM) begin
            next_out_ch = out_ch + 8'h1;
            if (out_ch == `LAST_CHANNEL) begin
               next_walk_on = 1'b0;
            end
         end
      end
      // a frame pulse restarts the walk; words not sent by then are dropped
      if (frame_pulse) begin
         next_bank = (bank == `LAST_BANK) ? 2'h0 : bank + 2'h1;
         next_out_ch = 8'h0;
         next_out_st = 5'h0;
         next_walk_on = 1'b1;
         next_seen_in = 1'b0;
         next_last_in_ch = 8'h0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         bank <= 2'h0;
         out_ch <= 8'h0;
         out_st <= 5'h0;
         walk_on <= 1'b0;
         seen_in <= 1'b0;
         last_in_ch <= 8'h0;
      end else begin
         bank <= next_bank;
         out_ch <= next_out_ch;
         out_st <= next_out_st;
         walk_on <= next_walk_on;
         seen_in <= next_seen_in;
         last_in_ch <= next_last_in_ch;
      end
   end

   out_word_type drain_word;

   out_buffer u_out_buffer (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .fill(link.sink),
      .drain_valid(out_valid),
      .drain_ready(out_ready),
      .drain_data(drain_word)
   );

   assign out_stream = drain_word.stream;
   assign out_channel = drain_word.channel;
   assign out_byte = drain_word.data;
   assign out_law_enable = drain_word.law_en;
   assign out_law_bits = drain_word.law_bits;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_block_min_time: assert property (bp_done |-> run_cnt >= 32'(BLOCK_CYCLES - 1))
      else $error("block program ended early");
   a_start_self_clear: assert property (bp_done && !wr_ims |=> !start)
      else $error("start bit not cleared at completion");
   a_block_abort: assert property ((state != bp_idle) && (!bpe || !start)
      |=> state == bp_idle)
      else $error("block program not aborted");
   a_pattern_fill: assert property (bp_write
      |=> cm_low[$past(clr_idx)] == {13'h0, $past(pattern)})
      else $error("low word not filled with pattern");
   a_high_zero: assert property (bp_write |=> cm_high[$past(clr_idx)] == 5'h0)
      else $error("high word not cleared");
   a_enable_kept: assert property (bpe && !wr_cr |=> bpe)
      else $error("block enable dropped without host write");
   a_law_gated: assert property (push && !word[`CW_LAW_EN_BIT]
      |-> !push_word.law_en && push_word.law_bits == 5'h0)
      else $error("law data passed while disabled");
   a_message_byte: assert property (push && word[`CW_SPECIAL_BIT]
      |-> push_word.data == word[`CW_MSG_MSB:`CW_MSG_LSB])
      else $error("message byte wrong");
   a_const_bank: assert property (push && !word[`CW_VAR_BIT]
      |-> rd_bank == bank_back(bank, 2'h2))
      else $error("constant delay bank wrong");
   a_var_bank: assert property (push && word[`CW_VAR_BIT] && !same_frame
      |-> rd_bank == bank_back(bank, 2'h1))
      else $error("variable delay bank wrong");
endmodule
`default_nettype wire

//--- sim/tdm_stream_partner.sv
// far-side model: frame timing, serial stream source and a stalling receiver
`timescale 1ns/1ps
`default_nettype none
module tdm_stream_partner (
   input wire logic ref_clk,
   output logic frame_pulse,
   output logic in_valid,
   output logic [4:0] in_stream,
   output logic [7:0] in_channel,
   output logic [7:0] in_byte,
   input wire logic out_valid,
   output logic out_ready,
   input wire logic [4:0] out_stream,
   input wire logic [7:0] out_channel,
   input wire logic [7:0] out_byte,
   input wire logic out_law_enable,
   input wire logic [4:0] out_law_bits
);
   logic [13:0] got [0:8191];
   logic [1:0] stall = 2'h0;

   initial begin
      frame_pulse = 1'b0;
      in_valid = 1'b0;
      in_stream = 5'h00;
      in_channel = 8'h00;
      in_byte = 8'h00;
      out_ready = 1'b0;
   end

   // ----------------------------------------
   // receiver: refuses one cycle in three
   // ----------------------------------------
   always @(posedge ref_clk) begin
      stall <= (stall == 2'h2) ? 2'h0 : stall + 2'h1;
      out_ready <= (stall != 2'h2);
      if (out_valid && out_ready) begin
         got[{out_stream, out_channel}] <= {out_law_enable, out_law_bits, out_byte};
      end
   end

   // ----------------------------------------
   // one frame: channels 0..15 of streams 0 and 1
   // ----------------------------------------
   task automatic send_frame(input logic [2:0] f);
      int c;
      int s;
      @(posedge ref_clk);
      frame_pulse <= 1'b1;
      @(posedge ref_clk);
      frame_pulse <= 1'b0;
      for (c = 0; c < 16; c++) begin
         for (s = 0; s < 2; s++) begin
            in_valid <= 1'b1;
            in_stream <= 5'(s);
            in_channel <= 8'(c);
            in_byte <= {f, s[0], c[3:0]};
            @(posedge ref_clk);
         end
      end
      in_valid <= 1'b0;
      // stale byte hidden so a late sample cannot pass by accident
      in_byte <= ~in_byte;
      repeat (1200) @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

//--- sim/tdm_switch_connection_memory_test.sv
// testbench of the switch connection memory and throughput delay
`timescale 1ns/1ps
`default_nettype none
module tdm_switch_connection_memory_test;
   logic ref_clk, reset_n, host_cs_n, host_ds_n, host_rw, host_data_oe, host_ack_n;
   logic [14:0] host_addr;
   logic [15:0] host_data_in, host_data_out, rd;
   logic frame_pulse, in_valid, out_valid, out_ready, out_law_enable;
   logic [4:0] in_stream, out_stream, out_law_bits;
   logic [7:0] in_channel, in_byte, out_channel, out_byte;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   int k;

   tdm_switch_connection_memory #(.BLOCK_CYCLES(16)) u_dut (.ref_clk(ref_clk),
      .reset_n(reset_n), .host_cs_n(host_cs_n), .host_ds_n(host_ds_n), .host_rw(host_rw),
      .host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
      .host_data_oe(host_data_oe), .host_ack_n(host_ack_n), .frame_pulse(frame_pulse),
      .in_valid(in_valid), .in_stream(in_stream), .in_channel(in_channel), .in_byte(in_byte),
      .out_valid(out_valid), .out_ready(out_ready), .out_stream(out_stream),
      .out_channel(out_channel), .out_byte(out_byte), .out_law_enable(out_law_enable),
      .out_law_bits(out_law_bits));

   tdm_stream_partner u_partner (.ref_clk(ref_clk), .frame_pulse(frame_pulse),
      .in_valid(in_valid), .in_stream(in_stream), .in_channel(in_channel), .in_byte(in_byte),
      .out_valid(out_valid), .out_ready(out_ready), .out_stream(out_stream),
      .out_channel(out_channel), .out_byte(out_byte), .out_law_enable(out_law_enable),
      .out_law_bits(out_law_bits));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         failures = failures + 1;
         results();
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic results();
      $display("comparisons %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_out(input logic [13:0] got, input logic [13:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: output %h expected %h", $time, got, exp);
      end
   endtask

   // strobes stay low until ack is seen, then ack must clear before the next access
   task automatic host_access(input logic rw, input logic [14:0] addr, input logic [15:0] wd);
      int n;
      @(posedge ref_clk);
      host_cs_n <= 1'b0;
      host_ds_n <= 1'b0;
      host_rw <= rw;
      host_addr <= addr;
      host_data_in <= wd;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (host_ack_n !== 1'b0 && n < 20);
      rd = host_data_out;
      if (n >= 20) check_word({15'h0000, host_ack_n}, 16'h0000);
      if (rw) check_word({15'h0000, host_data_oe}, 16'h0001);
      @(posedge ref_clk);
      host_cs_n <= 1'b1;
      host_ds_n <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (host_ack_n !== 1'b1 && n < 20);
      if (n >= 20) check_word({15'h0000, host_ack_n}, 16'h0001);
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic wr(input logic [14:0] addr, input logic [15:0] wd);
      host_access(1'b0, addr, wd);
   endtask

   task automatic rd_chk(input logic [14:0] addr, input logic [15:0] exp);
      host_access(1'b1, addr, 16'h0000);
      check_word(rd, exp);
   endtask

   function automatic logic [14:0] lo(input logic [4:0] s, input logic [7:0] c);
      return {2'h2, s, c};
   endfunction

   function automatic logic [14:0] hi(input logic [4:0] s, input logic [7:0] c);
      return {2'h3, s, c};
   endfunction

   function automatic logic [15:0] cw(input logic v, input logic [4:0] s, input logic [7:0] c);
      return {1'b0, v, s, c, 1'b0};
   endfunction

   function automatic logic [13:0] bt(input logic [2:0] f, input logic s, input logic [3:0] c);
      return {6'h00, f, s, c};
   endfunction

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      reset_n = 1'b0;
      host_cs_n = 1'b1;
      host_ds_n = 1'b1;
      host_rw = 1'b1;
      host_addr = 15'h0000;
      host_data_in = 16'h0000;
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      #1;
      check_word({host_ack_n, host_data_oe, out_valid, 13'h0000}, 16'h8000);
      // aborts: by the start bit, then by the enable bit
      wr(15'h0000, 16'h0008);
      wr(15'h0001, 16'h0001);
      host_access(1'b1, 15'h0002, 16'h0000);
      check_word(rd & 16'h0002, 16'h0002);
      wr(15'h0001, 16'h0000);
      host_access(1'b1, 15'h0002, 16'h0000);
      check_word(rd & 16'h0002, 16'h0000);
      wr(15'h0001, 16'h0001);
      wr(15'h0000, 16'h0000);
      host_access(1'b1, 15'h0002, 16'h0000);
      check_word(rd & 16'h0002, 16'h0000);
      wr(15'h0001, 16'h0000);
      // full block program with pattern 110
      wr(15'h0000, 16'h0008);
      wr(15'h0001, 16'h000C);
      wr(15'h0001, 16'h000D);
      k = 0;
      do begin
         host_access(1'b1, 15'h0002, 16'h0000);
         k++;
      end while (rd[1] !== 1'b0 && k < 2000);
      check_word(rd & 16'h0002, 16'h0000);
      rd_chk(15'h0001, 16'h000C);
      rd_chk(15'h0000, 16'h0008);
      rd_chk(lo(5'h13, 8'h27), 16'h0006);
      rd_chk(hi(5'h13, 8'h27), 16'h0000);
      wr(15'h0000, 16'h0000);
      // word widths and an unmapped place
      wr(lo(5'h1F, 8'hC8), 16'hBEEF);
      rd_chk(lo(5'h1F, 8'hC8), 16'hBEEF);
      wr(hi(5'h1F, 8'hC8), 16'hFFFF);
      rd_chk(hi(5'h1F, 8'hC8), 16'h001F);
      rd_chk(15'h0100, 16'h0000);
      // connections
      wr(lo(5'h00, 8'h00), 16'h0529);
      wr(lo(5'h01, 8'h00), cw(1'b1, 5'h00, 8'h00));
      wr(hi(5'h02, 8'h00), 16'h0015);
      wr(lo(5'h02, 8'h00), 16'h8529);
      wr(hi(5'h03, 8'h00), 16'h001F);
      wr(lo(5'h03, 8'h00), 16'h02D1);
      wr(lo(5'h04, 8'h01), cw(1'b0, 5'h00, 8'h01));
      wr(lo(5'h05, 8'h09), cw(1'b1, 5'h00, 8'h02));
      wr(lo(5'h06, 8'h03), cw(1'b1, 5'h00, 8'h01));
      wr(lo(5'h07, 8'h02), cw(1'b1, 5'h01, 8'h05));
      wr(lo(5'h08, 8'h08), cw(1'b1, 5'h01, 8'h01));
      wr(lo(5'h00, 8'h08), cw(1'b1, 5'h01, 8'h01));
      wr(lo(5'h09, 8'h0C), cw(1'b1, 5'h00, 8'h01));
      u_partner.send_frame(3'h0);
      check_out(u_partner.got[{5'h00, 8'h00}], 14'h00A5);
      check_out(u_partner.got[{5'h01, 8'h00}], 14'h00FF);
      check_out(u_partner.got[{5'h02, 8'h00}], {1'b1, 5'h15, 8'hA5});
      check_out(u_partner.got[{5'h03, 8'h00}], 14'h005A);
      wr(15'h0000, 16'h0010);
      u_partner.send_frame(3'h1);
      u_partner.send_frame(3'h2);
      u_partner.send_frame(3'h3);
      check_out(u_partner.got[{5'h04, 8'h01}], bt(3'h1, 1'b0, 4'h1));
      check_out(u_partner.got[{5'h05, 8'h09}], bt(3'h3, 1'b0, 4'h2));
      check_out(u_partner.got[{5'h06, 8'h03}], bt(3'h2, 1'b0, 4'h1));
      check_out(u_partner.got[{5'h07, 8'h02}], bt(3'h2, 1'b1, 4'h5));
      check_out(u_partner.got[{5'h08, 8'h08}], bt(3'h3, 1'b1, 4'h1));
      check_out(u_partner.got[{5'h00, 8'h08}], bt(3'h2, 1'b1, 4'h1));
      check_out(u_partner.got[{5'h09, 8'h0C}], bt(3'h3, 1'b0, 4'h1));
      results();
   end
endmodule
`default_nettype wire
